/* radio_cfg_pkg.sv */
// Purpose: Shared constants for the radio configuration register bank
// Assumes: 100 MHz sys_clk, APB with 32-bit data, word index = byte address / 4
// Notes:   Lock step counts derive from the step time and the clock period
`default_nettype none
package radio_cfg_pkg;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned LOCK_STEP_NS  = 2000;
  localparam int unsigned LOCK_STEP_CYC = (LOCK_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  LOCK_DEFAULT_STEPS = 8'h32;
  // Register indices (byte address is four times the index)
  localparam logic [11:0] IDX_RSSI_DELAY  = 12'h138;
  localparam logic [11:0] IDX_TEST_MODES  = 12'h139;
  localparam logic [11:0] IDX_TRANS_SPEED = 12'h13A;
  localparam logic [11:0] IDX_RX_LOCK     = 12'h13E;
  localparam logic [11:0] IDX_TX_LOCK     = 12'h13F;
  localparam logic [11:0] IDX_BANK_CTRL   = 12'h140;
  localparam logic [11:0] IDX_BANK_STATUS = 12'h141;
  localparam logic [11:0] IDX_AMP_LEVEL   = 12'h307;
  localparam logic [11:0] IDX_WAKE_UPPER  = 12'h30C;
  localparam logic [11:0] IDX_WAKE_LOWER  = 12'h30D;
  localparam logic [11:0] IDX_RELOAD_HI   = 12'h30E;
  localparam logic [11:0] IDX_RELOAD_LO   = 12'h30F;
  // Field positions
  localparam int unsigned TM_EXT_AMP  = 7;
  localparam int unsigned TM_AUTO_CLR = 3;
  localparam int unsigned TM_PER_ON   = 2;
  localparam int unsigned TM_REP_TX   = 1;
  localparam int unsigned TM_REP_RX   = 0;
  localparam int unsigned WU_COARSE   = 3;
  localparam int unsigned WU_PRESC    = 0;
  localparam int unsigned WL_RC_EN    = 6;
  localparam int unsigned WL_XTAL_EN  = 5;
  localparam int unsigned WL_CLK_SRC  = 4;
  localparam int unsigned WL_RET_PWR  = 3;
  localparam int unsigned WL_ARM      = 0;
  localparam int unsigned CT_LOCK_EN  = 0;
  localparam int unsigned ST_WAKE_FLG = 0;
  localparam int unsigned ST_RUNNING  = 1;
  localparam int unsigned ST_LOCK_BSY = 2;
  // Reset values and codes
  localparam logic [7:0]  RSSI_DELAY_RST = 8'hA7;
  localparam logic [7:0]  BYTE_RST       = 8'h00;
  localparam logic [7:0]  TRANS_FAST     = 8'h01;
  localparam logic [3:0]  COARSE_RST     = 4'h0;
  typedef enum logic [1:0] {LK_IDLE = 2'b00, LK_RUN = 2'b01, LK_DONE = 2'b11} lock_state_t;
  // Prescaler terminal count per code
  function automatic logic [15:0] presc_limit(input logic [2:0] code);
    unique case (code)
      3'h0: presc_limit = 16'h0000;
      3'h1: presc_limit = 16'h0003;
      3'h2: presc_limit = 16'h0007;
      3'h3: presc_limit = 16'h000F;
      3'h4: presc_limit = 16'h007F;
      3'h5: presc_limit = 16'h03FF;
      3'h6: presc_limit = 16'h1FFF;
      3'h7: presc_limit = 16'hFFFF;
    endcase
  endfunction
endpackage
`default_nettype wire

/* ctl_if.sv */
// Purpose: Carrier between the register bank and its two timers
// Assumes: All signals on sys_clk
// Notes:   Slow clock levels arrive already synchronised
`default_nettype none
interface ctl_if;
  logic        clkSel;
  logic        rcEn;
  logic        xtalEn;
  logic [2:0]  presc;
  logic [15:0] reloadValue;
  logic        reloadLoad;
  logic        rcSync;
  logic        xtalSync;
  logic        wakeEvent;
  logic        running;
  logic        customEn;
  logic [7:0]  rxWait;
  logic [7:0]  txWait;
  logic        startRx;
  logic        startTx;
  logic        done;
  logic        busy;
  modport wakeCtl (output clkSel, rcEn, xtalEn, presc, reloadValue, reloadLoad, rcSync, xtalSync,
                   input wakeEvent, running);
  modport wakeTmr (input clkSel, rcEn, xtalEn, presc, reloadValue, reloadLoad, rcSync, xtalSync,
                   output wakeEvent, running);
  modport lockCtl (output customEn, rxWait, txWait, startRx, startTx, input done, busy);
  modport lockTmr (input customEn, rxWait, txWait, startRx, startTx, output done, busy);
endinterface
`default_nettype wire

/* wake_timer.sv */
// Purpose: Wake-up prescaler and sixteen-bit down counter
// Assumes: Slow clock levels synchronised by the caller
// Notes:   A change of prescaler code keeps the running prescaler count; a count at or above the new limit ticks on the next slow edge
`default_nettype none
module wake_timer (
  input wire logic sys_clk,
  input wire logic sys_rst,
  ctl_if.wakeTmr   w
);
  logic        prevLvl;
  logic [15:0] presCnt;
  logic [15:0] count;
  logic        loaded;
  logic        slowLvl;
  logic        oscOn;
  logic        slowEdge;
  logic        tick;

  // Source and enable choice
  assign slowLvl  = w.clkSel ? w.rcSync : w.xtalSync;
  assign oscOn    = w.clkSel ? w.rcEn : w.xtalEn;
  assign slowEdge = slowLvl & ~prevLvl & oscOn;
  assign tick     = slowEdge && (presCnt >= radio_cfg_pkg::presc_limit(w.presc));
  assign w.running = loaded & oscOn;

  // Slow edge detect
  always_ff @(posedge sys_clk) begin
    if (sys_rst) prevLvl <= 1'b0;
    else prevLvl <= slowLvl;
  end

  // Prescaler
  always_ff @(posedge sys_clk) begin
    if (sys_rst) presCnt <= 16'h0000;
    else if (slowEdge) presCnt <= tick ? 16'h0000 : presCnt + 16'h0001;
  end

  // Down counter with reload and event
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      count       <= 16'h0000;
      loaded      <= 1'b0;
      w.wakeEvent <= 1'b0;
    end else begin
      w.wakeEvent <= 1'b0;
      if (w.reloadLoad) begin
        count  <= w.reloadValue;
        loaded <= 1'b1;
      end else if (tick && loaded) begin
        if (count == 16'h0000) begin
          w.wakeEvent <= 1'b1;
          count       <= w.reloadValue;
        end else begin
          count <= count - 16'h0001;
        end
      end
    end
  end

  wake_event_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    w.wakeEvent |-> $past(count) == 16'h0000 && $past(loaded)) else $error("wake event without zero count");
endmodule
`default_nettype wire

/* lock_timer.sv */
// Purpose: Synthesizer lock wait after VCO calibration
// Assumes: Start pulses come from same-clock sequencing logic
// Notes:   Starts while busy are ignored
`default_nettype none
module lock_timer (
  input wire logic sys_clk,
  input wire logic sys_rst,
  ctl_if.lockTmr   l
);
  localparam logic [7:0] STEP_LAST = 8'(radio_cfg_pkg::LOCK_STEP_CYC - 1);
  radio_cfg_pkg::lock_state_t state;
  logic [7:0] steps;
  logic [7:0] sub;
  logic [7:0] customSteps;

  // Custom or default length
  assign customSteps = l.startRx ? l.rxWait : l.txWait;
  assign l.busy      = (state != radio_cfg_pkg::LK_IDLE);
  assign l.done      = (state == radio_cfg_pkg::LK_DONE);

  // Step sequencer
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= radio_cfg_pkg::LK_IDLE;
      steps <= 8'h00;
      sub   <= 8'h00;
    end else begin
      unique case (state)
        radio_cfg_pkg::LK_IDLE: begin
          if (l.startRx || l.startTx) begin
            steps <= l.customEn ? customSteps : radio_cfg_pkg::LOCK_DEFAULT_STEPS;
            sub   <= STEP_LAST;
            state <= radio_cfg_pkg::LK_RUN;
          end
        end
        radio_cfg_pkg::LK_RUN: begin
          if (steps == 8'h00) state <= radio_cfg_pkg::LK_DONE;
          else if (sub == 8'h00) begin
            steps <= steps - 8'h01;
            sub   <= STEP_LAST;
          end else sub <= sub - 8'h01;
        end
        radio_cfg_pkg::LK_DONE: state <= radio_cfg_pkg::LK_IDLE;
        default: state <= radio_cfg_pkg::LK_IDLE;
      endcase
    end
  end

  sequence oneStepStart;
    !l.busy && l.customEn && l.startRx && l.rxWait == 8'h01;
  endsequence
  lock_one_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    oneStepStart |-> ##202 l.done) else $error("one step lock wait not 2 us");
endmodule
`default_nettype wire

/* radio_config_and_wakeup_regs.sv */
// Purpose: Radio configuration and wake-up register bank on APB
// Assumes: 100 MHz sys_clk, synchronous active-high reset, zero-wait APB slave
// Notes:   Slow oscillator pins pass two flops; sleep entry clears volatile state
//
// Functional notes
// - Eight-bit RSSI settle delay in microseconds; 0xA7 safe everywhere.
// - Select bit 1 routes amp controls to aux pins 3/4, else 1/2.
// - Self-clear bit makes TX-end and CRC-ok interrupt flags clear themselves.
// - Packet error rate bit turns that operation on or off.
// - Repeat transmit bit restarts TX after each packet.
// - Repeat receive bit restarts RX after each packet.
// - Speed code 0x01 fast, 0x00 and 0x04 normal, others reserved.
// - Custom enable uses RX lock field in 2 us steps.
// - Custom enable uses TX lock field in 2 us steps.
// - Volatile modem configuration lost on entering sleep.
// - Six-bit amplifier level 0..63, reset 0, ramp target.
// - Coarse tune code maps to ten tune states; 1101 is zero change.
// - Upper reload write pends until lower reload write; the auto-reload at each wake event already takes the pending upper byte.
// - Lower config bits enable RC and crystal slow oscillators.
// - Clock select 1 picks RC, 0 picks crystal.
// - Retention power bit keeps backed memory powered in sleep.
// - Arm bit lets timeouts wake the device.
// - Sixteen-bit reload counts down per tick; event at zero.
//
// Chosen here: the APB interface to the registers.
`default_nettype none
module radio_config_and_wakeup_regs (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [13:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sleepEnter,
  input  wire logic        slowRcClk,
  input  wire logic        slowXtalClk,
  input  wire logic        externalPowerAmpCtrl,
  input  wire logic        externalLowNoiseAmpCtrl,
  input  wire logic        vcoCalDoneRx,
  input  wire logic        vcoCalDoneTx,
  output logic      [7:0]  rssiSettleDelay,
  output logic             auxPin1,
  output logic             auxPin2,
  output logic             auxPin3,
  output logic             auxPin4,
  output logic             auxLowVoltMode,
  output logic             irqAutoClear,
  output logic             packetErrorRateOn,
  output logic             repeatTransmit,
  output logic             repeatReceive,
  output logic             fastTransition,
  output logic             lockDone,
  output logic      [5:0]  ampLevelTarget,
  output logic      [3:0]  rcOscCoarseTune,
  output logic      [3:0]  coarseTuneState,
  output logic      [2:0]  wakeTickDivider,
  output logic             rcOscEnable,
  output logic             crystalOscEnable,
  output logic             wakeClockSource,
  output logic             retentionPowerEnable,
  output logic             wakeArm,
  output logic             wakeUp
);
  ctl_if cif ();

  logic [11:0] regIdx;
  logic        aligned;
  logic        hit;
  logic        wrAcc;
  logic [7:0]  wByte;
  logic [7:0]  readByte;
  logic [7:0]  test_mode_controls;
  logic [7:0]  transSpeed;
  logic [7:0]  rxLockWait;
  logic [7:0]  txLockWait;
  logic        customLockEn;
  logic [7:0]  pendingUpper;
  logic [7:0]  reloadLower;
  logic        wakeFlag;
  logic [1:0]  slowMeta;
  logic [1:0]  slowSync;

  // Address decode
  assign regIdx  = paddr[13:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign wByte   = pwdata[7:0];
  assign pready  = 1'b1;
  always_comb begin
    unique case (regIdx)
      radio_cfg_pkg::IDX_RSSI_DELAY, radio_cfg_pkg::IDX_TEST_MODES, radio_cfg_pkg::IDX_TRANS_SPEED,
      radio_cfg_pkg::IDX_RX_LOCK, radio_cfg_pkg::IDX_TX_LOCK, radio_cfg_pkg::IDX_BANK_CTRL,
      radio_cfg_pkg::IDX_BANK_STATUS, radio_cfg_pkg::IDX_AMP_LEVEL, radio_cfg_pkg::IDX_WAKE_UPPER,
      radio_cfg_pkg::IDX_WAKE_LOWER, radio_cfg_pkg::IDX_RELOAD_HI,
      radio_cfg_pkg::IDX_RELOAD_LO: hit = aligned;
      default: hit = 1'b0;
    endcase
  end
  assign wrAcc   = psel && penable && pwrite && hit;
  assign pslverr = psel && penable && !hit;

  // Read mux; write-only registers read as zero
  always_comb begin
    unique case (regIdx)
      radio_cfg_pkg::IDX_RSSI_DELAY:  readByte = rssiSettleDelay;
      radio_cfg_pkg::IDX_TEST_MODES:  readByte = test_mode_controls;
      radio_cfg_pkg::IDX_TRANS_SPEED: readByte = transSpeed;
      radio_cfg_pkg::IDX_RX_LOCK:     readByte = rxLockWait;
      radio_cfg_pkg::IDX_TX_LOCK:     readByte = txLockWait;
      radio_cfg_pkg::IDX_BANK_CTRL:   readByte = {7'h00, customLockEn};
      radio_cfg_pkg::IDX_BANK_STATUS: readByte = {5'h00, cif.busy, cif.running, wakeFlag};
      radio_cfg_pkg::IDX_AMP_LEVEL:   readByte = {2'b00, ampLevelTarget};
      default:                        readByte = 8'h00;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) prdata <= 32'h0000_0000;
    else if (psel && !penable) prdata <= (hit && !pwrite) ? {24'h00_0000, readByte} : 32'h0000_0000;
  end

  // Battery-backed style configuration
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rssiSettleDelay <= radio_cfg_pkg::RSSI_DELAY_RST;
      test_mode_controls       <= radio_cfg_pkg::BYTE_RST;
      transSpeed      <= radio_cfg_pkg::BYTE_RST;
      rxLockWait      <= radio_cfg_pkg::BYTE_RST;
      txLockWait      <= radio_cfg_pkg::BYTE_RST;
      customLockEn    <= 1'b0;
    end else if (wrAcc) begin
      if (regIdx == radio_cfg_pkg::IDX_RSSI_DELAY) rssiSettleDelay <= wByte;
      if (regIdx == radio_cfg_pkg::IDX_TEST_MODES) test_mode_controls <= wByte;
      if (regIdx == radio_cfg_pkg::IDX_TRANS_SPEED) transSpeed <= wByte;
      if (regIdx == radio_cfg_pkg::IDX_RX_LOCK) rxLockWait <= wByte;
      if (regIdx == radio_cfg_pkg::IDX_TX_LOCK) txLockWait <= wByte;
      if (regIdx == radio_cfg_pkg::IDX_BANK_CTRL) customLockEn <= wByte[radio_cfg_pkg::CT_LOCK_EN];
    end
  end

  // Test mode decode
  assign irqAutoClear      = test_mode_controls[radio_cfg_pkg::TM_AUTO_CLR];
  assign packetErrorRateOn = test_mode_controls[radio_cfg_pkg::TM_PER_ON];
  assign repeatTransmit    = test_mode_controls[radio_cfg_pkg::TM_REP_TX];
  assign repeatReceive     = test_mode_controls[radio_cfg_pkg::TM_REP_RX];
  assign auxLowVoltMode    = test_mode_controls[radio_cfg_pkg::TM_EXT_AMP];
  // Reserved speed codes fall back to normal timing
  assign fastTransition    = (transSpeed == radio_cfg_pkg::TRANS_FAST);

  // External amplifier pin routing
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      auxPin1 <= 1'b0;
      auxPin2 <= 1'b0;
      auxPin3 <= 1'b0;
      auxPin4 <= 1'b0;
    end else begin
      auxPin1 <= !auxLowVoltMode && externalPowerAmpCtrl;
      auxPin2 <= !auxLowVoltMode && externalLowNoiseAmpCtrl;
      auxPin3 <= auxLowVoltMode && externalPowerAmpCtrl;
      auxPin4 <= auxLowVoltMode && externalLowNoiseAmpCtrl;
    end
  end

  // Volatile amplifier level and pending reload byte
  always_ff @(posedge sys_clk) begin
    if (sys_rst || sleepEnter) begin
      ampLevelTarget <= 6'h00;
      pendingUpper   <= radio_cfg_pkg::BYTE_RST;
    end else if (wrAcc) begin
      if (regIdx == radio_cfg_pkg::IDX_AMP_LEVEL) ampLevelTarget <= wByte[5:0];
      if (regIdx == radio_cfg_pkg::IDX_RELOAD_HI) pendingUpper <= wByte;
    end
  end

  // Wake configuration, upper then lower
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rcOscCoarseTune      <= radio_cfg_pkg::COARSE_RST;
      wakeTickDivider      <= 3'h0;
      rcOscEnable          <= 1'b0;
      crystalOscEnable     <= 1'b0;
      wakeClockSource      <= 1'b0;
      retentionPowerEnable <= 1'b0;
      wakeArm              <= 1'b0;
    end else if (wrAcc) begin
      if (regIdx == radio_cfg_pkg::IDX_WAKE_UPPER) begin
        rcOscCoarseTune <= wByte[radio_cfg_pkg::WU_COARSE +: 4];
        wakeTickDivider <= wByte[radio_cfg_pkg::WU_PRESC +: 3];
      end
      if (regIdx == radio_cfg_pkg::IDX_WAKE_LOWER) begin
        rcOscEnable          <= wByte[radio_cfg_pkg::WL_RC_EN];
        crystalOscEnable     <= wByte[radio_cfg_pkg::WL_XTAL_EN];
        wakeClockSource      <= wByte[radio_cfg_pkg::WL_CLK_SRC];
        retentionPowerEnable <= wByte[radio_cfg_pkg::WL_RET_PWR];
        wakeArm              <= wByte[radio_cfg_pkg::WL_ARM];
      end
    end
  end

  // Coarse tune code to state number, zero for unlisted codes
  always_comb begin
    unique case (rcOscCoarseTune)
      4'b0000: coarseTuneState = 4'hA;
      4'b0001: coarseTuneState = 4'h9;
      4'b1000: coarseTuneState = 4'h8;
      4'b1001: coarseTuneState = 4'h7;
      4'b1100: coarseTuneState = 4'h6;
      4'b1101: coarseTuneState = 4'h5;
      4'b1110: coarseTuneState = 4'h4;
      4'b1111: coarseTuneState = 4'h3;
      4'b0110: coarseTuneState = 4'h2;
      4'b0111: coarseTuneState = 4'h1;
      default: coarseTuneState = 4'h0;
    endcase
  end

  // Reload commit on the lower byte
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reloadLower    <= radio_cfg_pkg::BYTE_RST;
      cif.reloadLoad <= 1'b0;
    end else begin
      cif.reloadLoad <= wrAcc && (regIdx == radio_cfg_pkg::IDX_RELOAD_LO);
      if (wrAcc && regIdx == radio_cfg_pkg::IDX_RELOAD_LO) reloadLower <= wByte;
    end
  end

  // Slow oscillator pin synchronisers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      slowMeta <= 2'b00;
      slowSync <= 2'b00;
    end else begin
      slowMeta <= {slowXtalClk, slowRcClk};
      slowSync <= slowMeta;
    end
  end

  // Timer hookup
  assign cif.clkSel      = wakeClockSource;
  assign cif.rcEn        = rcOscEnable;
  assign cif.xtalEn      = crystalOscEnable;
  assign cif.presc       = wakeTickDivider;
  assign cif.reloadValue = {pendingUpper, reloadLower};
  assign cif.rcSync      = slowSync[0];
  assign cif.xtalSync    = slowSync[1];
  assign cif.customEn    = customLockEn;
  assign cif.rxWait      = rxLockWait;
  assign cif.txWait      = txLockWait;
  assign cif.startRx     = vcoCalDoneRx;
  assign cif.startTx     = vcoCalDoneTx;
  assign lockDone        = cif.done;

  wake_timer wakeTimer (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .w       (cif.wakeTmr)
  );

  lock_timer lockTimer (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .l       (cif.lockTmr)
  );

  // Wake output and sticky status flag, set beats clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wakeUp   <= 1'b0;
      wakeFlag <= 1'b0;
    end else begin
      wakeUp <= cif.wakeEvent && wakeArm;
      if (cif.wakeEvent) wakeFlag <= 1'b1;
      else if (wrAcc && regIdx == radio_cfg_pkg::IDX_BANK_STATUS && wByte[radio_cfg_pkg::ST_WAKE_FLG])
        wakeFlag <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence rssiWrite;
    wrAcc && regIdx == radio_cfg_pkg::IDX_RSSI_DELAY;
  endsequence
  sequence upperReloadOnly;
    wrAcc && regIdx == radio_cfg_pkg::IDX_RELOAD_HI;
  endsequence
  sequence lowerReload;
    wrAcc && regIdx == radio_cfg_pkg::IDX_RELOAD_LO;
  endsequence
  sequence speedWrite;
    wrAcc && regIdx == radio_cfg_pkg::IDX_TRANS_SPEED;
  endsequence
  sequence testModeWrite;
    wrAcc && regIdx == radio_cfg_pkg::IDX_TEST_MODES;
  endsequence
  sequence lowerConfigWrite;
    wrAcc && regIdx == radio_cfg_pkg::IDX_WAKE_LOWER;
  endsequence
  sequence statusClear;
    wrAcc && regIdx == radio_cfg_pkg::IDX_BANK_STATUS && wByte[radio_cfg_pkg::ST_WAKE_FLG];
  endsequence

  rssi_write_a: assert property (rssiWrite |=> rssiSettleDelay == $past(pwdata[7:0]))
    else $error("rssi delay not stored");
  aux_route_a: assert property (auxLowVoltMode && $stable(auxLowVoltMode)
    |=> auxPin3 == $past(externalPowerAmpCtrl) && !auxPin1)
    else $error("amp control routed to wrong aux pin");
  fast_decode_a: assert property (speedWrite |=>
    fastTransition == ($past(wByte) == radio_cfg_pkg::TRANS_FAST))
    else $error("fast timing does not follow speed code");
  sleep_clear_a: assert property (sleepEnter |=> ampLevelTarget == 6'h00 && pendingUpper == 8'h00)
    else $error("volatile state kept over sleep");
  reload_hold_a: assert property (upperReloadOnly |=> !cif.reloadLoad)
    else $error("upper reload applied without lower write");
  reload_commit_a: assert property (lowerReload ##1 1'b1 |-> cif.reloadLoad
    && cif.reloadValue[7:0] == $past(pwdata[7:0]))
    else $error("lower reload did not commit");
  wake_arm_a: assert property (wakeUp |-> $past(cif.wakeEvent) && $past(wakeArm))
    else $error("wake without armed timeout");
  coarse_zero_a: assert property (rcOscCoarseTune == 4'b1101 |-> coarseTuneState == 4'h5)
    else $error("zero change code maps wrong");
  flag_set_a: assert property (cif.wakeEvent |=> wakeFlag)
    else $error("timeout not registered");
  // Sticky flag clears only when no timeout competes
  flag_clear_a: assert property (statusClear ##0 !cif.wakeEvent |=> !wakeFlag)
    else $error("timeout flag not cleared");
  // Store checks for the loose control bits
  lower_store_a: assert property (lowerConfigWrite |=>
    {rcOscEnable, crystalOscEnable, wakeClockSource, retentionPowerEnable}
      == $past(wByte[radio_cfg_pkg::WL_RET_PWR +: 4]))
    else $error("lower wake config not stored");
  arm_store_a: assert property (lowerConfigWrite |=> wakeArm == $past(wByte[radio_cfg_pkg::WL_ARM]))
    else $error("arm bit not stored");
  test_store_a: assert property (testModeWrite |=>
    {irqAutoClear, packetErrorRateOn, repeatTransmit, repeatReceive}
      == $past(wByte[radio_cfg_pkg::TM_REP_RX +: 4]))
    else $error("test mode bits not stored");
endmodule
`default_nettype wire

/* tb.sv */
// Purpose: Self-checking bench for the radio configuration and wake-up register bank
// Assumes: Zero-wait APB slave, byte address is four times the register index
// Notes:   Both slow oscillator pins toggle freely; lock and wake waits are bounded
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, err, sleepEnter = 1'b0, slowRcClk = 1'b0, paCtl = 1'b0, lnaCtl = 1'b0;
  logic        calRx = 1'b0, aux1, aux2, aux3, aux4, lowV, autoClr, perOn, repTx, repRx, fastT, lockDone;
  logic        rcEn, xtalEn, clkSrc, retPwr, arm, wakeUp, calTx = 1'b0, xtalClk = 1'b0;
  logic [7:0]  rssi;
  logic [5:0]  ampLvl;
  logic [3:0]  coarse, tuneState;
  logic [2:0]  divider;
  int          num_errors = 0, cmp_count = 0, cycles = 0, n;
  // Clock and free-running slow oscillators
  always #5 sys_clk = ~sys_clk;
  always #15259 slowRcClk = ~slowRcClk;
  always #15259 xtalClk = ~xtalClk;
  radio_config_and_wakeup_regs radio_config_and_wakeup_regs_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleepEnter(sleepEnter),
    .slowRcClk(slowRcClk), .slowXtalClk(xtalClk), .externalPowerAmpCtrl(paCtl),
    .externalLowNoiseAmpCtrl(lnaCtl), .vcoCalDoneRx(calRx), .vcoCalDoneTx(calTx), .rssiSettleDelay(rssi),
    .auxPin1(aux1), .auxPin2(aux2), .auxPin3(aux3), .auxPin4(aux4), .auxLowVoltMode(lowV),
    .irqAutoClear(autoClr), .packetErrorRateOn(perOn), .repeatTransmit(repTx), .repeatReceive(repRx),
    .fastTransition(fastT), .lockDone(lockDone), .ampLevelTarget(ampLvl), .rcOscCoarseTune(coarse),
    .coarseTuneState(tuneState), .wakeTickDivider(divider), .rcOscEnable(rcEn), .crystalOscEnable(xtalEn),
    .wakeClockSource(clkSrc), .retentionPowerEnable(retPwr), .wakeArm(arm), .wakeUp(wakeUp));
  // Verdict and end of run
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      end_sim();
    end
  end
  // Value comparison
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] d);
    @(posedge sys_clk);
    psel <= 1'b1; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= {24'h00_0000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Let register outputs settle after a write
  task automatic settle();
    repeat (2) @(posedge sys_clk);
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    apb(0, radio_cfg_pkg::IDX_RSSI_DELAY, 8'h00); chk("rssi reset", 32'h0000_00A7, rd);
    apb(1, radio_cfg_pkg::IDX_RSSI_DELAY, 8'h3C); apb(0, radio_cfg_pkg::IDX_RSSI_DELAY, 8'h00);
    chk("rssi read", 32'h0000_003C, rd); chk("rssi out", 32'h0000_003C, {24'h0, rssi});
    chk("ready", 32'h1, {31'h0, pready});
    $display("test rssi done");
    paCtl <= 1'b1; lnaCtl <= 1'b0;
    apb(1, radio_cfg_pkg::IDX_TEST_MODES, 8'h8F); settle();
    chk("test bits", 32'h0000_001F, {27'h0, lowV, autoClr, perOn, repTx, repRx});
    chk("aux high pins", 32'h0000_0004, {28'h0, aux4, aux3, aux2, aux1});
    apb(1, radio_cfg_pkg::IDX_TEST_MODES, 8'h00); settle();
    chk("aux low pins", 32'h0000_0001, {28'h0, aux4, aux3, aux2, aux1});
    chk("test clear", 32'h0000_0000, {27'h0, lowV, autoClr, perOn, repTx, repRx});
    $display("test bits done");
    apb(1, radio_cfg_pkg::IDX_TRANS_SPEED, 8'h01); settle(); chk("fast code", 32'h1, {31'h0, fastT});
    apb(1, radio_cfg_pkg::IDX_TRANS_SPEED, 8'h04); settle(); chk("normal code", 32'h0, {31'h0, fastT});
    apb(1, radio_cfg_pkg::IDX_TRANS_SPEED, 8'h00); settle(); chk("zero code", 32'h0, {31'h0, fastT});
    $display("test speed done");
    apb(1, radio_cfg_pkg::IDX_AMP_LEVEL, 8'h3F); settle(); chk("amp level", 32'h3F, {26'h0, ampLvl});
    @(posedge sys_clk) sleepEnter <= 1'b1;
    @(posedge sys_clk) sleepEnter <= 1'b0;
    settle(); chk("amp after sleep", 32'h0, {26'h0, ampLvl});
    apb(0, radio_cfg_pkg::IDX_AMP_LEVEL, 8'h00); chk("amp read", 32'h0, rd);
    $display("test sleep done");
    apb(1, radio_cfg_pkg::IDX_BANK_CTRL, 8'h01);
    apb(1, radio_cfg_pkg::IDX_RX_LOCK, 8'h01);
    @(posedge sys_clk) calRx <= 1'b1;
    @(posedge sys_clk) calRx <= 1'b0;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (lockDone !== 1'b1 && n < 400);
    chk("rx lock cycles", 32'd202, n);
    apb(1, radio_cfg_pkg::IDX_TX_LOCK, 8'h02);
    @(posedge sys_clk) calTx <= 1'b1;
    @(posedge sys_clk) calTx <= 1'b0;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (lockDone !== 1'b1 && n < 600);
    chk("tx lock cycles", 32'd402, n);
    $display("test lock done");
    apb(1, radio_cfg_pkg::IDX_WAKE_UPPER, 8'h68); settle();
    chk("coarse code", 32'hD, {28'h0, coarse}); chk("tune state", 32'h5, {28'h0, tuneState});
    chk("divider", 32'h0, {29'h0, divider});
    apb(1, radio_cfg_pkg::IDX_WAKE_LOWER, 8'h59); settle();
    chk("lower bits", 32'h17, {27'h0, rcEn, xtalEn, clkSrc, retPwr, arm});
    apb(0, radio_cfg_pkg::IDX_WAKE_LOWER, 8'h00); chk("write only read", 32'h0, rd);
    apb(1, radio_cfg_pkg::IDX_RELOAD_HI, 8'h00);
    apb(1, radio_cfg_pkg::IDX_RELOAD_LO, 8'h02);
    n = 0;
    do begin @(posedge sys_clk); n++; end while (wakeUp !== 1'b1 && n < 20000);
    chk("wake seen", 32'h1, {31'h0, wakeUp});
    apb(0, radio_cfg_pkg::IDX_BANK_STATUS, 8'h00);
    chk("status flag", 32'h3, rd);
    apb(1, radio_cfg_pkg::IDX_BANK_STATUS, 8'h01);
    apb(0, radio_cfg_pkg::IDX_BANK_STATUS, 8'h00);
    chk("status clear", 32'h2, rd);
    $display("test wake done");
    apb(1, radio_cfg_pkg::IDX_WAKE_UPPER, 8'h69);
    settle();
    chk("divider four", 32'h1, {29'h0, divider});
    apb(1, radio_cfg_pkg::IDX_WAKE_LOWER, 8'h21);
    apb(1, radio_cfg_pkg::IDX_RELOAD_HI, 8'h00);
    apb(1, radio_cfg_pkg::IDX_RELOAD_LO, 8'h00);
    n = 0;
    do begin @(posedge sys_clk); n++; end while (wakeUp !== 1'b1 && n < 20000);
    chk("crystal wake", 32'h1, {31'h0, wakeUp});
    chk("slow tick wait", 32'h1, {31'h0, n >= 6000});
    $display("test crystal done");
    apb(1, 12'h001, 8'h55); chk("unmapped error", 32'h1, {31'h0, err});
    apb(0, 12'h001, 8'h00); chk("unmapped read", 32'h0, rd);
    $display("test unmapped done");
    end_sim();
  end
endmodule
`default_nettype wire
